/* logic/ipf_pkg.sv */
// Package for the interrupt priority field bank: offsets, field layout, types
package ipf_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned IPF_IDX_ADC_UART_TX  = 3;
  localparam int unsigned IPF_IDX_CN_CMP_I2C   = 4;
  localparam int unsigned IPF_IDX_EXT_INT1     = 5;
  localparam int unsigned IPF_IDX_EXT_INT2     = 7;
  localparam int unsigned IPF_IDX_PWM_SPECIAL  = 14;
  localparam int unsigned IPF_IDX_UART_ERROR   = 16;
  localparam int unsigned IPF_IDX_DEBUG_PORT   = 20;
  localparam int unsigned IPF_IDX_PWM_GEN12    = 23;
  localparam int unsigned IPF_IDX_PWM_GEN4     = 24;

  localparam int unsigned IPF_ADDR_W = 8;
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_ADC_UART_TX = 8'(IPF_IDX_ADC_UART_TX * 4);
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_CN_CMP_I2C  = 8'(IPF_IDX_CN_CMP_I2C * 4);
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_EXT_INT1    = 8'(IPF_IDX_EXT_INT1 * 4);
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_EXT_INT2    = 8'(IPF_IDX_EXT_INT2 * 4);
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_PWM_SPECIAL = 8'(IPF_IDX_PWM_SPECIAL * 4);
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_UART_ERROR  = 8'(IPF_IDX_UART_ERROR * 4);
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_DEBUG_PORT  = 8'(IPF_IDX_DEBUG_PORT * 4);
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_PWM_GEN12   = 8'(IPF_IDX_PWM_GEN12 * 4);
  localparam logic [IPF_ADDR_W-1:0] IPF_ADDR_PWM_GEN4    = 8'(IPF_IDX_PWM_GEN4 * 4);

  // Field low-bit positions inside a 16-bit priority register
  localparam int unsigned IPF_POS_LO  = 0;
  localparam int unsigned IPF_POS_ML  = 4;
  localparam int unsigned IPF_POS_MH  = 8;
  localparam int unsigned IPF_POS_HI  = 12;

  typedef logic [2:0] ipf_prio_t;
  localparam ipf_prio_t IPF_PRIO_RESET = 3'h4;
  localparam ipf_prio_t IPF_PRIO_OFF   = 3'h0;

  // Number of priority sources
  localparam int unsigned IPF_NSRC = 14;

  // Source order inside every per-source vector
  typedef enum logic [3:0] {
    IPF_SRC_ADC_DONE   = 4'h0,
    IPF_SRC_SERIAL_TX  = 4'h1,
    IPF_SRC_PIN_CHANGE = 4'h2,
    IPF_SRC_CMP_ONE    = 4'h3,
    IPF_SRC_TW_MASTER  = 4'h4,
    IPF_SRC_TW_SLAVE   = 4'h5,
    IPF_SRC_EXT_ONE    = 4'h6,
    IPF_SRC_EXT_TWO    = 4'h7,
    IPF_SRC_PWM_SPEC   = 4'h8,
    IPF_SRC_SERIAL_ERR = 4'h9,
    IPF_SRC_DEBUG_PORT = 4'hA,
    IPF_SRC_PWM_ONE    = 4'hB,
    IPF_SRC_PWM_TWO    = 4'hC,
    IPF_SRC_PWM_FOUR   = 4'hD
  } ipf_src_e;

  // All priority fields held by the bank
  typedef struct packed {
    ipf_prio_t adc_done_prio;
    ipf_prio_t serial_tx_prio;
    ipf_prio_t pin_change_prio;
    ipf_prio_t comparator_one_prio;
    ipf_prio_t two_wire_master_prio;
    ipf_prio_t two_wire_slave_prio;
    ipf_prio_t ext_irq_one_prio;
    ipf_prio_t ext_irq_two_prio;
    ipf_prio_t pwm_special_event_prio;
    ipf_prio_t serial_error_prio;
    ipf_prio_t debug_port_prio;
    ipf_prio_t pwm_gen_one_prio;
    ipf_prio_t pwm_gen_two_prio;
    ipf_prio_t pwm_gen_four_prio;
  } ipf_fields_s;

  // APB request bundle
  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [IPF_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } ipf_apb_req_s;

endpackage

/* logic/ipf_bank.sv */
// Interrupt priority field bank with an APB slave and per-source level outputs
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
import ipf_pkg::*;

// Function
// - Three-bit priority field per source; 111 means level 7, the highest.
// - Field 001 is level 1; values 001..111 map linearly to levels 1..7.
// - Field 000 disables the source; it is not presented for service from one cycle after its field reads 000.
// - Unassigned bit positions of priority registers read back as zero.
// - Each implemented field resets to 100, giving level 4.
// - Register 3: ADC done at bits 6-4, serial transmit at 2-0.
// - Register 4: pin change 14-12, comparator 10-8, two-wire master 6-4, slave 2-0.
// - Register 5: external interrupt 1 at bits 2-0, rest zero.
// - Register 7: external interrupt 2 at bits 6-4, rest zero.
// - Register 14: PWM special event at bits 6-4, rest zero.
// - Register 16: serial error at bits 6-4, rest zero.
// - Register 20: debug port at bits 2-0, rest zero.
// - Register 23: PWM generator 2 at 14-12, generator 1 at 10-8.
// - Register 24: PWM generator 4 at bits 6-4, rest zero.
// - A build parameter removes an absent peripheral's field, leaving unused bits.
// - After any reset all present sources start at level 4 until rewritten; absent ones read zero.
module ipf_bank #(
  parameter logic [ipf_pkg::IPF_NSRC-1:0] SRC_PRESENT = '1
) (
  input  wire logic                              ref_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [ipf_pkg::IPF_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  input  wire logic [ipf_pkg::IPF_NSRC-1:0]      src_request,
  output logic                                   pready,
  output logic [31:0]                            prdata,
  output logic                                   pslverr,
  output ipf_pkg::ipf_fields_s                   prio_fields,
  output logic [ipf_pkg::IPF_NSRC-1:0]           service_req
);
  import ipf_pkg::*;

  // Elaboration check: at least one source must be present
  if (SRC_PRESENT == '0) begin : g_chk
    $error("ipf_bank: no source present");
  end

  typedef struct packed {
    ipf_fields_s         fields;
    logic                ready;
    logic [31:0]         rdata;
    logic                slverr;
    logic [IPF_NSRC-1:0] svc;
  } ipf_state_s;

  // Reset image: present fields at level 4, absent fields held at zero from the first edge
  function automatic ipf_fields_s reset_fields();
    logic [IPF_NSRC*3-1:0] flat;
    for (int unsigned i = 0; i < IPF_NSRC; i++) begin
      flat[(IPF_NSRC-1-i)*3 +: 3] = SRC_PRESENT[i] ? IPF_PRIO_RESET : IPF_PRIO_OFF;
    end
    reset_fields = flat;
  endfunction

  localparam ipf_fields_s FIELDS_RST = reset_fields();

  ipf_state_s st_reg;
  ipf_state_s st_next;

  ipf_apb_req_s req;
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Masks a field to zero when its peripheral is absent in this build
  function automatic ipf_prio_t keep(input ipf_src_e s, input ipf_prio_t v);
    keep = SRC_PRESENT[s] ? v : IPF_PRIO_OFF;
  endfunction

  // Places a field into a 16-bit word at its position
  function automatic logic [15:0] place(input ipf_prio_t v, input int unsigned pos);
    place = 16'(v) << pos;
  endfunction

  // Takes a field out of write data at its position; the caller checks the field's byte lane strobe
  function automatic ipf_prio_t take(input logic [31:0] d, input int unsigned pos);
    take = d[pos +: 3];
  endfunction

  // Fields as a flat per-source vector in source order
  function automatic ipf_prio_t prio_of(input ipf_fields_s f, input int unsigned i);
    logic [IPF_NSRC*3-1:0] flat;
    flat = f;
    prio_of = flat[(IPF_NSRC-1-i)*3 +: 3];
  endfunction

  // Read word assembly; all unassigned bits stay zero
  function automatic logic [31:0] read_word(input ipf_fields_s f, input logic [IPF_ADDR_W-1:0] a);
    logic [15:0] w;
    w = 16'h0000;
    unique case (a)
      IPF_ADDR_ADC_UART_TX: w = place(f.adc_done_prio, IPF_POS_ML)
                              | place(f.serial_tx_prio, IPF_POS_LO);
      IPF_ADDR_CN_CMP_I2C:  w = place(f.pin_change_prio, IPF_POS_HI)
                              | place(f.comparator_one_prio, IPF_POS_MH)
                              | place(f.two_wire_master_prio, IPF_POS_ML)
                              | place(f.two_wire_slave_prio, IPF_POS_LO);
      IPF_ADDR_EXT_INT1:    w = place(f.ext_irq_one_prio, IPF_POS_LO);
      IPF_ADDR_EXT_INT2:    w = place(f.ext_irq_two_prio, IPF_POS_ML);
      IPF_ADDR_PWM_SPECIAL: w = place(f.pwm_special_event_prio, IPF_POS_ML);
      IPF_ADDR_UART_ERROR:  w = place(f.serial_error_prio, IPF_POS_ML);
      IPF_ADDR_DEBUG_PORT:  w = place(f.debug_port_prio, IPF_POS_LO);
      IPF_ADDR_PWM_GEN12:   w = place(f.pwm_gen_two_prio, IPF_POS_HI)
                              | place(f.pwm_gen_one_prio, IPF_POS_MH);
      IPF_ADDR_PWM_GEN4:    w = place(f.pwm_gen_four_prio, IPF_POS_ML);
      default:              w = 16'h0000;
    endcase
    read_word = {16'h0000, w};
  endfunction

  // True for the nine mapped word addresses
  function automatic logic mapped(input logic [IPF_ADDR_W-1:0] a);
    mapped = (a == IPF_ADDR_ADC_UART_TX) || (a == IPF_ADDR_CN_CMP_I2C) ||
             (a == IPF_ADDR_EXT_INT1) || (a == IPF_ADDR_EXT_INT2) ||
             (a == IPF_ADDR_PWM_SPECIAL) || (a == IPF_ADDR_UART_ERROR) ||
             (a == IPF_ADDR_DEBUG_PORT) || (a == IPF_ADDR_PWM_GEN12) ||
             (a == IPF_ADDR_PWM_GEN4);
  endfunction

  // Next state: APB access, field updates and service gating
  always_comb begin
    logic        acc;
    logic        wr;
    logic [1:0]  lanes;
    ipf_fields_s f;
    acc   = 1'b0;
    wr    = 1'b0;
    lanes = 2'b00;
    f     = st_reg.fields;
    st_next = st_reg;
    // Registered answer: pready rises one cycle after the first access cycle, giving one wait state
    acc = req.psel && req.penable && !st_reg.ready;
    st_next.ready  = acc;
    st_next.slverr = acc && !mapped(req.paddr);
    st_next.rdata  = 32'h0000_0000;
    wr    = acc && req.pwrite && mapped(req.paddr);
    lanes = pstrb[1:0];
    if (acc && !req.pwrite) begin
      st_next.rdata = read_word(st_reg.fields, req.paddr);
    end
    // Only the three-bit fields are written; other bits are dropped
    if (wr) begin
      unique case (req.paddr)
        IPF_ADDR_ADC_UART_TX: begin
          if (lanes[0]) f.adc_done_prio  = take(req.pwdata, IPF_POS_ML);
          if (lanes[0]) f.serial_tx_prio = take(req.pwdata, IPF_POS_LO);
        end
        IPF_ADDR_CN_CMP_I2C: begin
          if (lanes[1]) f.pin_change_prio      = take(req.pwdata, IPF_POS_HI);
          if (lanes[1]) f.comparator_one_prio  = take(req.pwdata, IPF_POS_MH);
          if (lanes[0]) f.two_wire_master_prio = take(req.pwdata, IPF_POS_ML);
          if (lanes[0]) f.two_wire_slave_prio  = take(req.pwdata, IPF_POS_LO);
        end
        IPF_ADDR_EXT_INT1: begin
          if (lanes[0]) f.ext_irq_one_prio = take(req.pwdata, IPF_POS_LO);
        end
        IPF_ADDR_EXT_INT2: begin
          if (lanes[0]) f.ext_irq_two_prio = take(req.pwdata, IPF_POS_ML);
        end
        IPF_ADDR_PWM_SPECIAL: begin
          if (lanes[0]) f.pwm_special_event_prio = take(req.pwdata, IPF_POS_ML);
        end
        IPF_ADDR_UART_ERROR: begin
          if (lanes[0]) f.serial_error_prio = take(req.pwdata, IPF_POS_ML);
        end
        IPF_ADDR_DEBUG_PORT: begin
          if (lanes[0]) f.debug_port_prio = take(req.pwdata, IPF_POS_LO);
        end
        IPF_ADDR_PWM_GEN12: begin
          if (lanes[1]) f.pwm_gen_two_prio = take(req.pwdata, IPF_POS_HI);
          if (lanes[1]) f.pwm_gen_one_prio = take(req.pwdata, IPF_POS_MH);
        end
        IPF_ADDR_PWM_GEN4: begin
          if (lanes[0]) f.pwm_gen_four_prio = take(req.pwdata, IPF_POS_ML);
        end
        default: ;
      endcase
    end
    // Absent peripherals keep a zero field whatever software writes
    f.adc_done_prio          = keep(IPF_SRC_ADC_DONE, f.adc_done_prio);
    f.serial_tx_prio         = keep(IPF_SRC_SERIAL_TX, f.serial_tx_prio);
    f.pin_change_prio        = keep(IPF_SRC_PIN_CHANGE, f.pin_change_prio);
    f.comparator_one_prio    = keep(IPF_SRC_CMP_ONE, f.comparator_one_prio);
    f.two_wire_master_prio   = keep(IPF_SRC_TW_MASTER, f.two_wire_master_prio);
    f.two_wire_slave_prio    = keep(IPF_SRC_TW_SLAVE, f.two_wire_slave_prio);
    f.ext_irq_one_prio       = keep(IPF_SRC_EXT_ONE, f.ext_irq_one_prio);
    f.ext_irq_two_prio       = keep(IPF_SRC_EXT_TWO, f.ext_irq_two_prio);
    f.pwm_special_event_prio = keep(IPF_SRC_PWM_SPEC, f.pwm_special_event_prio);
    f.serial_error_prio      = keep(IPF_SRC_SERIAL_ERR, f.serial_error_prio);
    f.debug_port_prio        = keep(IPF_SRC_DEBUG_PORT, f.debug_port_prio);
    f.pwm_gen_one_prio       = keep(IPF_SRC_PWM_ONE, f.pwm_gen_one_prio);
    f.pwm_gen_two_prio       = keep(IPF_SRC_PWM_TWO, f.pwm_gen_two_prio);
    f.pwm_gen_four_prio      = keep(IPF_SRC_PWM_FOUR, f.pwm_gen_four_prio);
    st_next.fields = f;
    // A zero level blocks the request; levels 1..7 pass unchanged to arbitration
    for (int unsigned i = 0; i < IPF_NSRC; i++) begin
      st_next.svc[i] = src_request[i] && (prio_of(st_reg.fields, i) != IPF_PRIO_OFF);
    end
  end

  // Reset loads level 4 into every present field
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg.fields <= FIELDS_RST;
      st_reg.ready  <= 1'b0;
      st_reg.rdata  <= 32'h0000_0000;
      st_reg.slverr <= 1'b0;
      st_reg.svc    <= '0;
      // Absent fields never show level 4, so arbitration cannot see a phantom source
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register; the field value is the level
  assign pready      = st_reg.ready;
  assign prdata      = st_reg.rdata;
  assign pslverr     = st_reg.slverr;
  assign prio_fields = st_reg.fields;
  assign service_req = st_reg.svc;

  // Checks
  a_zero_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (prio_of(st_reg.fields, 0) == IPF_PRIO_OFF) |=> !service_req[0])
    else $error("disabled source presented");
  a_reset_level: assert property (@(posedge ref_clk)
    $fell(sys_rst) |-> (!SRC_PRESENT[0] || prio_fields.adc_done_prio == IPF_PRIO_RESET))
    else $error("field not level 4 after reset");
  a_upper_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pready |-> prdata[31:15] == 17'h00000)
    else $error("unused upper bits not zero");
  a_ready_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("no answer after access");
  a_write_adc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && penable && !pready && pwrite && paddr == IPF_ADDR_ADC_UART_TX && pstrb[0]
     && SRC_PRESENT[IPF_SRC_ADC_DONE])
    |=> prio_fields.adc_done_prio == $past(pwdata[6:4]))
    else $error("adc field write lost");
  a_write_pwm: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && penable && !pready && pwrite && paddr == IPF_ADDR_PWM_GEN12 && pstrb[1]
     && SRC_PRESENT[IPF_SRC_PWM_TWO])
    |=> prio_fields.pwm_gen_two_prio == $past(pwdata[14:12]))
    else $error("pwm gen2 field write lost");
  a_read_ext1: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && penable && !pready && !pwrite && paddr == IPF_ADDR_EXT_INT1)
    |=> prdata[15:0] == {13'h0000, $past(prio_fields.ext_irq_one_prio)})
    else $error("ext1 read wrong");
  a_read_dbg: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && penable && !pready && !pwrite && paddr == IPF_ADDR_DEBUG_PORT)
    |=> prdata[15:3] == 13'h0000)
    else $error("debug register unused bits set");
  a_absent_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !SRC_PRESENT[IPF_SRC_PWM_FOUR] |=> prio_fields.pwm_gen_four_prio == IPF_PRIO_OFF)
    else $error("absent field not zero");
  a_svc_pass: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (src_request[1] && prio_of(st_reg.fields, 1) != IPF_PRIO_OFF) |=> service_req[1])
    else $error("enabled source not presented");

  c_write: cover property (@(posedge ref_clk) pready && pwrite && !pslverr);
  c_read: cover property (@(posedge ref_clk) pready && !pwrite && prdata != 32'h0000_0000);
  c_unmapped: cover property (@(posedge ref_clk) pready && pslverr);
  c_blocked: cover property (@(posedge ref_clk) src_request[0] && prio_fields.adc_done_prio == IPF_PRIO_OFF);

endmodule

/* dv/ipf_src_model.sv */
// Source-side partner: presents combined flag-and-enable requests to the bank
module ipf_src_model (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic [ipf_pkg::IPF_NSRC-1:0] want,
  output logic      [ipf_pkg::IPF_NSRC-1:0] src_request
);
  timeunit 1ns;
  timeprecision 1ps;
  import ipf_pkg::*;

  // Requests change only after an edge; held quiet while the device is in reset
  always_ff @(posedge ref_clk) begin
    src_request <= sys_rst ? '0 : want;
  end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the interrupt priority field bank over APB
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ipf_pkg::*;

  logic                  ref_clk  = 1'b0;
  logic                  sys_rst  = 1'b1;
  logic                  psel     = 1'b0;
  logic                  penable  = 1'b0;
  logic                  pwrite   = 1'b0;
  logic [IPF_ADDR_W-1:0] paddr    = '0;
  logic [31:0]           pwdata   = '0;
  logic [3:0]            pstrb    = 4'hF;
  logic [IPF_NSRC-1:0]   want     = '0;
  logic [IPF_NSRC-1:0]   src_request;
  logic                  pready, pready_b, pslverr, pslverr_b;
  logic [31:0]           prdata, prdata_b, rd_data, rd_data2;
  logic                  rd_err;
  ipf_fields_s           prio_fields;
  logic [IPF_NSRC-1:0]   service_req, service_req_b;
  int                    mismatches = 0;
  int                    checked    = 0;

  // Register map: address and implemented-field mask of each word
  logic [IPF_ADDR_W-1:0] addr_tab [9] = '{IPF_ADDR_ADC_UART_TX, IPF_ADDR_CN_CMP_I2C, IPF_ADDR_EXT_INT1,
    IPF_ADDR_EXT_INT2, IPF_ADDR_PWM_SPECIAL, IPF_ADDR_UART_ERROR, IPF_ADDR_DEBUG_PORT, IPF_ADDR_PWM_GEN12,
    IPF_ADDR_PWM_GEN4};
  logic [31:0] mask_tab [9] = '{32'h00000077, 32'h00007777, 32'h00000007, 32'h00000070, 32'h00000070,
    32'h00000070, 32'h00000007, 32'h00007700, 32'h00000070};
  // Variant without the serial transmitter loses bits 2-0 of the first word
  localparam logic [IPF_NSRC-1:0] PRESENT_B = 14'h3FFD;

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  ipf_bank DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .src_request(src_request), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .prio_fields(prio_fields), .service_req(service_req));
  // Second bank on the same bus, built with one source removed
  ipf_bank #(.SRC_PRESENT(PRESENT_B)) DUT_ABSENT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .src_request(src_request), .pready(pready_b), .prdata(prdata_b), .pslverr(pslverr_b),
    .prio_fields(), .service_req(service_req_b));
  ipf_src_model SRC (.ref_clk(ref_clk), .sys_rst(sys_rst), .want(want), .src_request(src_request));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One APB transfer; an idle edge first so no signal is driven twice in a time step
  task automatic apb_xfer(input logic wr, input logic [IPF_ADDR_W-1:0] a, input logic [31:0] d,
                          input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      stop_test();
    end
    rd_data  = prdata;
    rd_err   = pslverr;
    rd_data2 = prdata_b;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] mask_b(input int i);
    return (i == 0) ? 32'h00000070 : mask_tab[i];
  endfunction

  // Write a pattern to every word, then read each back through both banks
  task automatic write_all_read(input logic [31:0] pat);
    for (int i = 0; i < 9; i++) begin
      apb_xfer(1'b1, addr_tab[i], pat, 4'hF);
    end
    for (int i = 0; i < 9; i++) begin
      apb_xfer(1'b0, addr_tab[i], 32'h0, 4'hF);
      `CHK(rd_data, mask_tab[i] & pat)
      `CHK(rd_data2, mask_b(i) & pat)
      `CHK(rd_err, 1'b0)
    end
  endtask

  // Requests settle through the model and the one-cycle service path
  task automatic check_service(input logic [IPF_NSRC-1:0] ea, input logic [IPF_NSRC-1:0] eb);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(service_req, ea)
    `CHK(service_req_b, eb)
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    want    <= '1;
    // Every implemented field comes up at level 4
    for (int i = 0; i < 9; i++) begin
      apb_xfer(1'b0, addr_tab[i], 32'h0, 4'hF);
      `CHK(rd_data, mask_tab[i] & 32'h44444444)
      `CHK(rd_data2, mask_b(i) & 32'h44444444)
    end
    `CHK(prio_fields, {14{3'h4}})
    check_service('1, PRESENT_B);
    $display("test reset_values done");
    // All ones: only field bits stick, each field at level 7
    write_all_read(32'hFFFFFFFF);
    `CHK(prio_fields, {14{3'h7}})
    $display("test all_ones done");
    // Pattern 001 in every nibble gives level 1 everywhere
    write_all_read(32'h11111111);
    `CHK(prio_fields, {14{3'h1}})
    check_service('1, PRESENT_B);
    $display("test level_one done");
    // Level 0 masks every pending request
    write_all_read(32'h00000000);
    `CHK(prio_fields, {14{3'h0}})
    check_service('0, '0);
    $display("test disabled done");
    // Lane 0 strobe only: upper lane fields stay at zero
    apb_xfer(1'b1, IPF_ADDR_CN_CMP_I2C, 32'hFFFFFFFF, 4'h1);
    apb_xfer(1'b0, IPF_ADDR_CN_CMP_I2C, 32'h0, 4'hF);
    `CHK(rd_data, 32'h00000077)
    // Unmapped word answers with an error and zero data
    apb_xfer(1'b1, 8'h08, 32'hFFFFFFFF, 4'hF);
    apb_xfer(1'b0, 8'h08, 32'h0, 4'hF);
    `CHK(rd_data, 32'h00000000)
    `CHK(rd_err, 1'b1)
    $display("test strobe_unmapped done");
    // Second reset in mid-run restores level 4
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb_xfer(1'b0, IPF_ADDR_CN_CMP_I2C, 32'h0, 4'hF);
    `CHK(rd_data, 32'h00004444)
    apb_xfer(1'b0, IPF_ADDR_ADC_UART_TX, 32'h0, 4'hF);
    `CHK(rd_data2, 32'h00000040)
    `CHK(prio_fields, {14{3'h4}})
    $display("test second_reset done");
    stop_test();
  end
endmodule
